// ===== logic/ckc_pkg.sv
// Package for the clock source control block: offsets, fields, resets and timing.
package ckc_pkg;
    localparam logic [7:0] CKC_CLOCK_CONTROL_ADDR = 8'h8e;
    localparam logic [7:0] CKC_CLOCK_DIVIDER_ADDR = 8'h95;
    localparam logic [7:0] CKC_SWITCH_ADDR        = 8'h96;
    localparam logic [7:0] CKC_SOURCE_ENABLE_ADDR = 8'h97;
    localparam logic [7:0] CKC_CLOCK_CONTROL_RST  = 8'h00;
    localparam logic [7:0] CKC_CLOCK_DIVIDER_RST  = 8'h00;
    localparam logic [7:0] CKC_SOURCE_ENABLE_RST  = 8'h30;
    localparam logic [1:0] CKC_SOURCE_SEL_RST     = 2'h0;
    localparam int         CKC_EXT_SEL_HI         = 7;
    localparam int         CKC_EXT_SEL_LO         = 6;
    localparam int         CKC_FAST_ON_BIT        = 5;
    localparam int         CKC_SLOW_ON_BIT        = 4;
    localparam int         CKC_FAULT_BIT          = 0;
    localparam int         CKC_CLK_OUT_ON_BIT     = 1;
    localparam int         CKC_PIN_ROUTE_BIT      = 7;
    localparam int         CKC_SEL_HI             = 2;
    localparam int         CKC_SEL_LO             = 1;
    localparam logic [7:0] CKC_UNLOCK_KEY_A       = 8'haa;
    localparam logic [7:0] CKC_UNLOCK_KEY_B       = 8'h55;
    localparam int         CKC_CLK_PERIOD_NS      = 50;
    localparam int         CKC_UNLOCK_WINDOW_NS   = 200;
    localparam int         CKC_UNLOCK_CYCLES      = CKC_UNLOCK_WINDOW_NS / CKC_CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        CKC_SRC_FAST,
        CKC_SRC_EXT,
        CKC_SRC_SLOW,
        CKC_SRC_RSVD
    } ckc_src_t;

    typedef enum logic [1:0]
    {
        CKC_EXT_OFF,
        CKC_EXT_CRYSTAL,
        CKC_EXT_PIN_B,
        CKC_EXT_PIN_A
    } ckc_ext_t;
endpackage

// ===== logic/ckc_unlock.sv
// Timed-access unlock sequencer that opens a short write window.
`timescale 1ns/1ps
`default_nettype none
module ckc_unlock
(
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Key writes and the protected write.
    input  wire logic       key_wr,
    input  wire logic [7:0] key_data,
    input  wire logic       prot_wr,
    // Window state.
    output logic            window_open
);
    import ckc_pkg::*;

    typedef enum logic [1:0]
    {
        CKC_UL_IDLE,
        CKC_UL_HALF,
        CKC_UL_OPEN
    } ckc_ul_t;

    ckc_ul_t    state;
    logic [3:0] count;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= CKC_UL_IDLE;
            count <= 4'h0;
        end
        else
        begin
            case (state)
                CKC_UL_IDLE:
                begin
                    if (key_wr && key_data == CKC_UNLOCK_KEY_A)
                    begin
                        state <= CKC_UL_HALF;
                        count <= 4'(CKC_UNLOCK_CYCLES);
                    end
                end
                CKC_UL_HALF:
                begin
                    if (key_wr && key_data == CKC_UNLOCK_KEY_B)
                    begin
                        state <= CKC_UL_OPEN;
                        count <= 4'(CKC_UNLOCK_CYCLES);
                    end
                    else if (key_wr || count == 4'h0)
                        state <= CKC_UL_IDLE;
                    else
                        count <= count - 4'h1;
                end
                CKC_UL_OPEN:
                begin
                    if (prot_wr || count == 4'h0)
                        state <= CKC_UL_IDLE;
                    else
                        count <= count - 4'h1;
                end
                default:
                    state <= CKC_UL_IDLE;
            endcase
        end
    end

    assign window_open = (state == CKC_UL_OPEN);
endmodule // ckc_unlock
`default_nettype wire

// ===== logic/ckc_divider.sv
// Glitch-free even divider that makes the system clock enable and output wave.
`timescale 1ns/1ps
`default_nettype none
module ckc_divider
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // Divider setting and halt.
    input  wire logic [WIDTH-1:0] div_value,
    input  wire logic             halt,
    // Divided outputs.
    output logic                  sys_tick,
    output logic                  sys_wave
);
    import ckc_pkg::*;

    logic [WIDTH-1:0] count;
    logic             half_done;

    assign half_done = (count + WIDTH'(1) >= div_value);

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count    <= '0;
            sys_wave <= 1'b0;
        end
        else if (!halt)
        begin
            if (div_value == '0)
                sys_wave <= ~sys_wave;
            else if (half_done)
            begin
                count    <= '0;
                sys_wave <= ~sys_wave;
            end
            else
                count <= count + WIDTH'(1);
        end
    end

    assign sys_tick = !halt && ((div_value == '0) || (half_done && sys_wave));
endmodule // ckc_divider
`default_nettype wire

// ===== logic/ckc_clock_ctrl.sv
// Clock source control: enables, switching, fault flag, divider and clock output.
//
// Contract
// [R1] External select 11/10/01 enables pin A/B/crystal.
// [R2] External select 00 releases all external pins.
// [R3] Bit 5 turns fast oscillator on.
// [R4] Self programming forces fast oscillator on.
// [R5] Leaving self programming restores fast bits.
// [R6] Bit 4 turns slow oscillator on.
// [R7] Slow disable ignored while users need it.
// [R8] Bit 0 reads switch fault flag.
// [R9] Fault held until unstable target stabilises.
// [R10] System clock is oscillator over twice divider.
// [R11] Divider changes apply anytime without stalling.
// [R12] Clock output enable drives system clock out.
// [R13] Clock output stops during power down.
// [R14] Route bit chooses clock output pin.
// [R15] Enable register writes need unlock window.
// [R16] Software avoids clock output when noise matters.
// [R17] Disabling current source is ignored entirely.
// [R18] Disabled target: field updates, clock stays, fault.
// [R19] Unstable target: wait, switch, clear fault.
// [R20] Source field: fast, external, slow.
// [R21] Divider zero passes oscillator clock through.
`timescale 1ns/1ps
`default_nettype none
module ckc_clock_ctrl
#(
    parameter int DIV_WIDTH = 8
)
(
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Special function register port.
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       ta_key_wr,
    // System context.
    input  wire logic       self_prog_on,
    input  wire logic       dog_timer_on,
    input  wire logic       wakeup_timer_slow,
    input  wire logic       brownout_detect_on,
    input  wire logic       low_voltage_reset_filter,
    input  wire logic       power_down,
    input  wire logic       pin_route_sel,
    // Oscillator stability.
    input  wire logic       fast_osc_ready,
    input  wire logic       slow_osc_ready,
    input  wire logic       ext_crystal_ready,
    input  wire logic       ext_clk_in_a_ready,
    input  wire logic       ext_clk_in_b_ready,
    // Oscillator and pin controls.
    output logic            fast_osc_en,
    output logic            slow_osc_en,
    output logic            ext_crystal_en,
    output logic            ext_clk_in_a_en,
    output logic            ext_clk_in_b_en,
    output ckc_pkg::ckc_src_t active_src,
    output logic            sys_tick,
    // Clock output pins.
    output logic            clk_out_pin_a,
    output logic            clk_out_pin_a_oe,
    output logic            clk_out_pin_b,
    output logic            clk_out_pin_b_oe
);
    import ckc_pkg::*;

    logic [1:0] ext_source_sel;
    logic       fast_osc_on;
    logic       fast_osc_saved;
    logic       slow_osc_on;
    logic       switch_fault_flag;
    logic [1:0] source_sel;
    ckc_src_t   running_src;
    logic [7:0] clock_divider_reg;
    logic [7:0] clock_control_reg;
    logic       self_prog_prev;
    logic       window_open;
    logic       en_wr;
    logic       sel_wr;
    logic       slow_locked;
    logic       next_fast;
    logic       next_slow;
    logic [1:0] next_ext;
    logic       fast_osc_stable;
    logic       sys_wave;
    logic       clk_out_on;

    // Is a given source enabled, for a given set of enable bits.
    function automatic logic src_enabled(input logic [1:0] src, input logic fast,
                                         input logic slow, input logic [1:0] ext);
        case (src)
            CKC_SRC_FAST: src_enabled = fast;
            CKC_SRC_EXT:  src_enabled = (ext != CKC_EXT_OFF);
            CKC_SRC_SLOW: src_enabled = slow;
            default:      src_enabled = 1'b0;
        endcase
    endfunction

    // Is a given source stable right now.
    function automatic logic src_stable(input logic [1:0] src);
        case (src)
            CKC_SRC_FAST: src_stable = fast_osc_stable;
            CKC_SRC_SLOW: src_stable = slow_osc_en && slow_osc_ready;
            CKC_SRC_EXT:
            begin
                case (ext_source_sel)
                    CKC_EXT_CRYSTAL: src_stable = ext_crystal_ready;
                    CKC_EXT_PIN_B:   src_stable = ext_clk_in_b_ready;
                    CKC_EXT_PIN_A:   src_stable = ext_clk_in_a_ready;
                    default:         src_stable = 1'b0;
                endcase
            end
            default:      src_stable = 1'b0;
        endcase
    endfunction

    // [R15] Unlock window gate.
    ckc_unlock u_unlock
    (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .key_wr      (ta_key_wr),
        .key_data    (sfr_wdata),
        .prot_wr     (en_wr || sel_wr),
        .window_open (window_open)
    );

    assign en_wr  = sfr_wr && window_open && sfr_addr == CKC_SOURCE_ENABLE_ADDR;
    assign sel_wr = sfr_wr && window_open && sfr_addr == CKC_SWITCH_ADDR;

    // [R7] Slow oscillator lock.
    assign slow_locked = dog_timer_on || wakeup_timer_slow || brownout_detect_on || low_voltage_reset_filter;

    // Candidate enable values of a write, before protection checks.
    always_comb
    begin
        next_ext  = sfr_wdata[CKC_EXT_SEL_HI:CKC_EXT_SEL_LO];
        next_fast = sfr_wdata[CKC_FAST_ON_BIT];
        // [R7] Keep slow on.
        next_slow = sfr_wdata[CKC_SLOW_ON_BIT] || slow_locked;
    end

    // [R3] [R6] [R17] Enable register update with protection.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ext_source_sel <= CKC_SOURCE_ENABLE_RST[CKC_EXT_SEL_HI:CKC_EXT_SEL_LO];
            fast_osc_on    <= CKC_SOURCE_ENABLE_RST[CKC_FAST_ON_BIT];
            slow_osc_on    <= CKC_SOURCE_ENABLE_RST[CKC_SLOW_ON_BIT];
        end
        else if (en_wr && src_enabled(running_src, next_fast, next_slow, next_ext))
        begin
            ext_source_sel <= next_ext;
            fast_osc_on    <= next_fast;
            slow_osc_on    <= next_slow;
        end
        // [R5] Restore saved fast bit.
        else if (self_prog_prev && !self_prog_on
                 && src_enabled(running_src, fast_osc_saved, slow_osc_en, ext_source_sel))
            fast_osc_on <= fast_osc_saved;
        else if (slow_locked)
            slow_osc_on <= 1'b1;
    end

    // [R4] [R5] Save fast bit on entry to self programming.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            self_prog_prev <= 1'b0;
            fast_osc_saved <= 1'b0;
        end
        else
        begin
            self_prog_prev <= self_prog_on;
            if (self_prog_on && !self_prog_prev)
                fast_osc_saved <= fast_osc_on;
        end
    end

    // [R4] Forced fast enable.
    assign fast_osc_en     = self_prog_on || fast_osc_on;
    assign fast_osc_stable = self_prog_on || (fast_osc_on && fast_osc_ready);
    assign slow_osc_en     = slow_osc_on || slow_locked;

    // [R1] [R2] External source enables.
    assign ext_crystal_en  = (ext_source_sel == CKC_EXT_CRYSTAL);
    assign ext_clk_in_b_en = (ext_source_sel == CKC_EXT_PIN_B);
    assign ext_clk_in_a_en = (ext_source_sel == CKC_EXT_PIN_A);

    // [R18] [R19] [R20] Source select, background switch and fault flag.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            source_sel        <= CKC_SOURCE_SEL_RST;
            running_src       <= CKC_SRC_FAST;
            switch_fault_flag <= 1'b0;
        end
        else if (sel_wr)
        begin
            source_sel <= sfr_wdata[CKC_SEL_HI:CKC_SEL_LO];
            if (sfr_wdata[CKC_SEL_HI:CKC_SEL_LO] == CKC_SRC_RSVD)
                switch_fault_flag <= 1'b1;
            else if (src_stable(sfr_wdata[CKC_SEL_HI:CKC_SEL_LO]))
            begin
                running_src       <= ckc_src_t'(sfr_wdata[CKC_SEL_HI:CKC_SEL_LO]);
                switch_fault_flag <= 1'b0;
            end
            else
                switch_fault_flag <= 1'b1;
        end
        // [R9] Complete pending switch once stable.
        else if (source_sel != running_src && source_sel != CKC_SRC_RSVD
                 && src_enabled(source_sel, fast_osc_en, slow_osc_en, ext_source_sel)
                 && src_stable(source_sel))
        begin
            running_src       <= ckc_src_t'(source_sel);
            switch_fault_flag <= 1'b0;
        end
    end

    assign active_src = running_src;

    // [R11] Divider and control registers, writable at any time.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            clock_divider_reg <= CKC_CLOCK_DIVIDER_RST;
            clock_control_reg <= CKC_CLOCK_CONTROL_RST;
        end
        else if (sfr_wr && sfr_addr == CKC_CLOCK_DIVIDER_ADDR)
            clock_divider_reg <= sfr_wdata;
        else if (sfr_wr && sfr_addr == CKC_CLOCK_CONTROL_ADDR)
            clock_control_reg <= sfr_wdata;
    end

    // [R10] [R13] [R21] Divide by twice the setting, halt in power down.
    ckc_divider #(.WIDTH(DIV_WIDTH)) u_divider
    (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .div_value (clock_divider_reg[DIV_WIDTH-1:0]),
        .halt      (power_down),
        .sys_tick  (sys_tick),
        .sys_wave  (sys_wave)
    );

    // [R12] [R14] Clock output routing.
    assign clk_out_on       = clock_control_reg[CKC_CLK_OUT_ON_BIT];
    assign clk_out_pin_a    = sys_wave;
    assign clk_out_pin_b    = sys_wave;
    assign clk_out_pin_a_oe = clk_out_on && !pin_route_sel;
    assign clk_out_pin_b_oe = clk_out_on && pin_route_sel;

    // [R8] Read back, fault flag in bit 0.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
        begin
            case (sfr_addr)
                CKC_CLOCK_CONTROL_ADDR: sfr_rdata <= clock_control_reg;
                CKC_CLOCK_DIVIDER_ADDR: sfr_rdata <= clock_divider_reg;
                CKC_SOURCE_ENABLE_ADDR: sfr_rdata <= {ext_source_sel, fast_osc_en, slow_osc_en,
                                                      3'h0, switch_fault_flag};
                CKC_SWITCH_ADDR:        sfr_rdata <= {2'h0, fast_osc_stable, 5'h00};
                default:                sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule // ckc_clock_ctrl
`default_nettype wire

// ===== dv/ckc_clock_ctrl_properties.sv
// Assertion checker for the clock source control block.
`timescale 1ns/1ps
`default_nettype none
module ckc_clock_ctrl_checker
(
    // Clock and reset.
    input wire logic              core_clk,
    input wire logic              rstn,
    // Watched ports.
    input wire logic              sfr_rd,
    input wire logic [7:0]        sfr_rdata,
    input wire logic              self_prog_on,
    input wire logic              dog_timer_on,
    input wire logic              wakeup_timer_slow,
    input wire logic              brownout_detect_on,
    input wire logic              low_voltage_reset_filter,
    input wire logic              power_down,
    input wire logic              pin_route_sel,
    input wire logic              fast_osc_ready,
    input wire logic              slow_osc_ready,
    input wire logic              fast_osc_en,
    input wire logic              slow_osc_en,
    input wire logic              ext_crystal_en,
    input wire logic              ext_clk_in_a_en,
    input wire logic              ext_clk_in_b_en,
    input wire ckc_pkg::ckc_src_t active_src,
    input wire logic              clk_out_pin_a,
    input wire logic              clk_out_pin_a_oe,
    input wire logic              clk_out_pin_b,
    input wire logic              clk_out_pin_b_oe
);
    import ckc_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_ext_onehot; $onehot0({ext_crystal_en, ext_clk_in_a_en, ext_clk_in_b_en}); endproperty
    a_ext_onehot: assert property (p_ext_onehot) else $error("more than one external source enabled");
    property p_prog_fast; self_prog_on |-> fast_osc_en; endproperty
    a_prog_fast: assert property (p_prog_fast) else $error("fast oscillator off during self programming");
    property p_slow_keep;
        (dog_timer_on || wakeup_timer_slow || brownout_detect_on || low_voltage_reset_filter) |-> slow_osc_en;
    endproperty
    a_slow_keep: assert property (p_slow_keep) else $error("slow oscillator off while a user needs it");
    property p_route_a; clk_out_pin_a_oe |-> !pin_route_sel && !clk_out_pin_b_oe; endproperty
    a_route_a: assert property (p_route_a) else $error("clock output on wrong pin");
    property p_route_b; clk_out_pin_b_oe |-> pin_route_sel; endproperty
    a_route_b: assert property (p_route_b) else $error("second clock output pin enabled wrongly");
    property p_halt;
        power_down && $past(power_down) |-> $stable(clk_out_pin_a) && $stable(clk_out_pin_b);
    endproperty
    a_halt: assert property (p_halt) else $error("clock output toggles in power down");
    property p_run_on;
        (active_src != CKC_SRC_FAST || fast_osc_en) && (active_src != CKC_SRC_SLOW || slow_osc_en);
    endproperty
    a_run_on: assert property (p_run_on) else $error("running source disabled");
    property p_switch_ready;
        $changed(active_src) |-> (active_src != CKC_SRC_FAST || $past(fast_osc_ready))
            && (active_src != CKC_SRC_SLOW || $past(slow_osc_ready));
    endproperty
    a_switch_ready: assert property (p_switch_ready) else $error("switched to an unstable source");
    property p_rd_hold; !$past(sfr_rd) |-> $stable(sfr_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");
endmodule // ckc_clock_ctrl_checker
bind ckc_clock_ctrl ckc_clock_ctrl_checker u_chk (.core_clk(core_clk), .rstn(rstn), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .self_prog_on(self_prog_on), .dog_timer_on(dog_timer_on),
    .wakeup_timer_slow(wakeup_timer_slow), .brownout_detect_on(brownout_detect_on),
    .low_voltage_reset_filter(low_voltage_reset_filter), .power_down(power_down), .pin_route_sel(pin_route_sel),
    .fast_osc_ready(fast_osc_ready), .slow_osc_ready(slow_osc_ready), .fast_osc_en(fast_osc_en),
    .slow_osc_en(slow_osc_en), .ext_crystal_en(ext_crystal_en), .ext_clk_in_a_en(ext_clk_in_a_en),
    .ext_clk_in_b_en(ext_clk_in_b_en), .active_src(active_src), .clk_out_pin_a(clk_out_pin_a),
    .clk_out_pin_a_oe(clk_out_pin_a_oe), .clk_out_pin_b(clk_out_pin_b), .clk_out_pin_b_oe(clk_out_pin_b_oe));
`default_nettype wire

// ===== dv/ckc_clock_ctrl_tb.sv
// Self-checking testbench for the clock source control block.
`timescale 1ns/1ps
`default_nettype none
module ckc_clock_ctrl_tb;
    import ckc_pkg::*;
    logic       core_clk, rstn, sfr_wr, sfr_rd, ta_key_wr, self_prog_on, power_down, pin_route_sel;
    logic       dog_timer_on, wakeup_timer_slow, brownout_detect_on, low_voltage_reset_filter;
    logic       fast_osc_ready, slow_osc_ready, ext_crystal_ready, ext_clk_in_a_ready, ext_clk_in_b_ready;
    logic       fast_osc_en, slow_osc_en, ext_crystal_en, ext_clk_in_a_en, ext_clk_in_b_en, sys_tick, fault_m;
    logic       clk_out_pin_a, clk_out_pin_a_oe, clk_out_pin_b, clk_out_pin_b_oe;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv, en_m;
    ckc_src_t   active_src;
    int         fail_count, compares, src_m, n, cnt;
    int         dv[$] = '{0, 1, 255};
    ckc_clock_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ta_key_wr(ta_key_wr),
        .self_prog_on(self_prog_on), .dog_timer_on(dog_timer_on), .wakeup_timer_slow(wakeup_timer_slow),
        .brownout_detect_on(brownout_detect_on), .low_voltage_reset_filter(low_voltage_reset_filter),
        .power_down(power_down), .pin_route_sel(pin_route_sel), .fast_osc_ready(fast_osc_ready),
        .slow_osc_ready(slow_osc_ready), .ext_crystal_ready(ext_crystal_ready),
        .ext_clk_in_a_ready(ext_clk_in_a_ready), .ext_clk_in_b_ready(ext_clk_in_b_ready),
        .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en), .ext_crystal_en(ext_crystal_en),
        .ext_clk_in_a_en(ext_clk_in_a_en), .ext_clk_in_b_en(ext_clk_in_b_en), .active_src(active_src),
        .sys_tick(sys_tick), .clk_out_pin_a(clk_out_pin_a), .clk_out_pin_a_oe(clk_out_pin_a_oe),
        .clk_out_pin_b(clk_out_pin_b), .clk_out_pin_b_oe(clk_out_pin_b_oe));
    task automatic conclude();
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic key, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        ta_key_wr <= key;
        sfr_wr    <= !key;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge core_clk);
        ta_key_wr <= 1'b0;
        sfr_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        sfr_rd   <= 1'b1;
        sfr_addr <= a;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        rv = sfr_rdata;
    endtask
    function automatic logic lock();
        return dog_timer_on | wakeup_timer_slow | brownout_detect_on | low_voltage_reset_filter;
    endfunction
    // Protected write to the enable register, mirrored in the model unless it would stop a running fast or slow source.
    task automatic wen(input logic [7:0] d);
        bus(1'b1, 8'h00, CKC_UNLOCK_KEY_A);
        bus(1'b1, 8'h00, CKC_UNLOCK_KEY_B);
        bus(1'b0, CKC_SOURCE_ENABLE_ADDR, d);
        if (!((src_m == 0 && !d[5]) || (src_m == 2 && !d[4] && !lock())))
            en_m = {d[7:5], d[4] | lock(), 4'h0};
    endtask
    task automatic sw(input logic [1:0] s);
        bus(1'b1, 8'h00, CKC_UNLOCK_KEY_A);
        bus(1'b1, 8'h00, CKC_UNLOCK_KEY_B);
        bus(1'b0, CKC_SWITCH_ADDR, {5'h0, s, 1'b0});
    endtask
    task automatic chk_en();
        rd(CKC_SOURCE_ENABLE_ADDR);
        chk(16'(rv), {8'h0, en_m[7:6], en_m[5] | self_prog_on, en_m[4] | lock(), 3'h0, fault_m});
        chk({11'h0, fast_osc_en, slow_osc_en, ext_clk_in_a_en, ext_clk_in_b_en, ext_crystal_en},
            {11'h0, en_m[5] | self_prog_on, en_m[4] | lock(), en_m[7:6] == 2'h3, en_m[7:6] == 2'h2,
             en_m[7:6] == 2'h1});
        chk(16'(active_src), 16'(src_m));
    endtask
    task automatic gap();
        cnt = 1;
        @(posedge core_clk);
        #1;
        while (sys_tick !== 1'b1 && cnt < 600)
        begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
    endtask
    task automatic toggles(input int cyc);
        logic p;
        #1;
        p = pin_route_sel ? clk_out_pin_b : clk_out_pin_a;
        n = 0;
        repeat (cyc)
        begin
            @(posedge core_clk);
            #1;
            if ((pin_route_sel ? clk_out_pin_b : clk_out_pin_a) !== p)
                n++;
            p = pin_route_sel ? clk_out_pin_b : clk_out_pin_a;
        end
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial
    begin
        #(50 * 20000);
        fail_count++;
        conclude();
    end
    initial
    begin
        {rstn, sfr_wr, sfr_rd, ta_key_wr, self_prog_on, power_down, pin_route_sel} = '0;
        {dog_timer_on, wakeup_timer_slow, brownout_detect_on, low_voltage_reset_filter} = '0;
        {fast_osc_ready, slow_osc_ready, ext_crystal_ready, ext_clk_in_a_ready, ext_clk_in_b_ready} = '1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        en_m = CKC_SOURCE_ENABLE_RST;
        src_m = 0;
        fault_m = 1'b0;
        void'($urandom(29));
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        rd(CKC_CLOCK_CONTROL_ADDR);
        chk(16'(rv), 16'(CKC_CLOCK_CONTROL_RST));
        chk_en();
        bus(1'b0, CKC_SOURCE_ENABLE_ADDR, 8'h00);
        chk_en();
        for (int i = 0; i < 4; i++)
        begin
            wen({2'(i), 6'h30});
            chk_en();
        end
        @(posedge core_clk);
        {dog_timer_on, wakeup_timer_slow, brownout_detect_on, low_voltage_reset_filter} <= 4'(1 << $urandom_range(3));
        wen(8'h20);
        chk_en();
        @(posedge core_clk);
        {dog_timer_on, wakeup_timer_slow, brownout_detect_on, low_voltage_reset_filter} <= 4'h0;
        slow_osc_ready <= 1'b0;
        wen(8'h20);
        chk_en();
        wen(8'h10);
        chk_en();
        wen(8'h30);
        sw(2'h2);
        fault_m = 1'b1;
        repeat (3) @(posedge core_clk);
        chk_en();
        @(posedge core_clk);
        slow_osc_ready <= 1'b1;
        cnt = 0;
        while (active_src !== CKC_SRC_SLOW && cnt < 50)
        begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
        src_m = 2;
        fault_m = 1'b0;
        chk_en();
        wen(8'h10);
        chk_en();
        @(posedge core_clk);
        self_prog_on <= 1'b1;
        chk_en();
        rd(CKC_SWITCH_ADDR);
        chk(16'(rv[5]), 16'h1);
        @(posedge core_clk);
        self_prog_on <= 1'b0;
        chk_en();
        rd(CKC_SWITCH_ADDR);
        chk(16'(rv[5]), 16'h0);
        sw(2'h0);
        fault_m = 1'b1;
        chk_en();
        dv.push_back($urandom_range(20, 2));
        foreach (dv[i])
        begin
            bus(1'b0, CKC_CLOCK_DIVIDER_ADDR, 8'(dv[i]));
            rd(CKC_CLOCK_DIVIDER_ADDR);
            chk(16'(rv), 16'(dv[i]));
            gap();
            gap();
            chk(16'(cnt), (dv[i] == 0) ? 16'h1 : 16'(2 * dv[i]));
        end
        bus(1'b0, CKC_CLOCK_DIVIDER_ADDR, 8'h02);
        bus(1'b0, CKC_CLOCK_CONTROL_ADDR, 8'h02);
        for (int r = 0; r < 2; r++)
        begin
            @(posedge core_clk);
            pin_route_sel <= 1'(r);
            toggles(16);
            chk(16'(n), 16'h8);
            chk({14'h0, clk_out_pin_a_oe, clk_out_pin_b_oe}, (r == 0) ? 16'h2 : 16'h1);
        end
        @(posedge core_clk);
        power_down <= 1'b1;
        gap();
        chk(16'(cnt), 16'd600);
        toggles(16);
        chk(16'(n), 16'h0);
        @(posedge core_clk);
        power_down <= 1'b0;
        bus(1'b0, CKC_CLOCK_CONTROL_ADDR, 8'h00);
        #1;
        chk({14'h0, clk_out_pin_a_oe, clk_out_pin_b_oe}, 16'h0);
        conclude();
    end
endmodule // ckc_clock_ctrl_tb
`default_nettype wire
